// File: design/fsp_host.sv
// Rules from the flash document that this block works to
// RL1: The flash blocks program and erase inside any protected sector group.
// RL2: Four sectors form one group, chosen by the top five address bits.
// RL3: A finished unprotect gives program and erase back to protected groups.
// RL4: Protect and unprotect are plain bus writes with elevated reset voltage applied.
// RL5: Host protects every still unprotected group before the first unprotect write.
// RL6: Every group leaves the factory unprotected.
// RL7: Under elevated reset voltage the flash lets protected groups be altered.
// RL8: Removing elevated voltage brings back all earlier group protection.
// RL9: The flash holds a 128 word secure region and a fixed lock indicator bit.
// RL10: Secure words 0 to 7 hold a serial number; the rest vary by variant.
// RL11: After the enter sequence, first sector reads come from the secure region.
// RL12: Secure mapping lasts until exit or power loss; hardware reset ends it.
// RL13: An unlocked secure region takes every programming method.
// RL14: A locked secure region can never be unlocked or changed.
// RL15: Lock the secure region by enter sequence then protect, any reset level.
// RL16: Factory locked parts arrive with the secure region already protected.
// RL17: Host exits the secure region before touching the rest of the array; the host still lets OP_VERIFY read any group while in it.
// RL18: Only full unlock sequences start program or erase.
// RL19: Below the lockout supply level the flash ignores writes and reads array.
// RL20: Strobe pulses under 5 ns never start a write cycle.
// RL21: Writes need chip select and write enable low with output enable high.
// RL22: Writes during power-up are ignored and the flash starts in read mode.
// RL23: A group verify read returns 01h for protected and 00h for unprotected.
// RL24: Elevated reset voltage is modelled as its own digital qualifier.
`timescale 1ns/1ns
`default_nettype none
module fsp_host (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic [fsp_pkg::AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output var  logic                      s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output var  logic                      s_axi_wready,
    output var  logic [1:0]                s_axi_bresp,
    output var  logic                      s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [fsp_pkg::AXI_AW-1:0] s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output var  logic                      s_axi_arready,
    output var  logic [31:0]               s_axi_rdata,
    output var  logic [1:0]                s_axi_rresp,
    output var  logic                      s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    output var  logic [fsp_pkg::FL_AW-1:0] fl_addr,
    output var  logic [fsp_pkg::FL_DW-1:0] fl_dq_o,
    output var  logic                      fl_dq_oe,
    input  wire logic [fsp_pkg::FL_DW-1:0] fl_dq_i,
    output var  logic                      fl_ce_n,
    output var  logic                      fl_oe_n,
    output var  logic                      fl_we_n,
    output var  logic                      fl_reset_n,
    output var  logic                      elevated_id_voltage
);
    import fsp_pkg::*;

    typedef enum logic [1:0] {
        H_IDLE = 2'b01,
        H_RUN  = 2'b10
    } fsp_hst_t;

    fsp_cyc_if cyc ();

    fsp_cycle u_cycle (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .cyc        (cyc),
        .fl_addr_r  (fl_addr),
        .fl_dq_o_r  (fl_dq_o),
        .fl_dq_oe_r (fl_dq_oe),
        .fl_dq_i    (fl_dq_i),
        .fl_ce_n_r  (fl_ce_n),
        .fl_oe_n_r  (fl_oe_n),
        .fl_we_n_r  (fl_we_n)
    );

    fsp_hst_t               hst_r;
    logic [2:0]             op_r;
    logic [FL_AW-1:0]       addr_r;
    logic [FL_DW-1:0]       wdata_r;
    logic [FL_DW-1:0]       rdata_r;
    logic [2:0]             cfg_r;
    logic [NUM_GRP-1:0]     shadow_r;
    logic                   done_r;
    logic                   refused_r;
    logic                   grp_prot_r;
    logic                   aw_hold_r;
    logic                   w_hold_r;
    logic [AXI_AW-1:0]      waddr_r;
    logic [31:0]            wdat_r;
    logic                   wfull_r;
    logic                   w_full;
    logic                   aw_fire;
    logic                   w_fire;
    logic                   wr_do;
    logic [AXI_AW-1:0]      wa;
    logic [31:0]            wd;
    logic                   cmd_wr;
    logic                   legal;
    logic [GRP_W-1:0]       grp;
    logic                   in_first;

    assign aw_fire  = s_axi_awvalid & s_axi_awready;
    assign w_fire   = s_axi_wvalid & s_axi_wready;
    assign wr_do    = (aw_hold_r | aw_fire) & (w_hold_r | w_fire) & ~s_axi_bvalid;
    assign wa       = aw_fire ? s_axi_awaddr : waddr_r;
    assign wd       = w_fire ? s_axi_wdata : wdat_r;
    assign w_full   = w_fire ? (&s_axi_wstrb) : wfull_r;
    assign cmd_wr   = wr_do && (wa == REG_CMD) && w_full;
    assign grp      = addr_r[GRP_LSB +: GRP_W]; // [RL2]
    assign in_first = (addr_r[FL_AW-1:7] == '0) && (addr_r[6:0] <= SEC_LIMIT[6:0]);

    // Requests that would break the flash's protection protocol are refused before any pin moves.
    always_comb
    begin
        legal = 1'b1;
        unique case (wd[2:0])
            OP_WRITE, OP_READ:
                legal = ~cfg_r[CFG_SEC] | in_first; // [RL17]
            OP_PROTECT:
                legal = cfg_r[CFG_ELEV] | cfg_r[CFG_SEC]; // [RL4] [RL15]
            OP_UNPROTECT:
                legal = cfg_r[CFG_ELEV] & (&shadow_r) & ~cfg_r[CFG_SEC]; // [RL4] [RL5]
            OP_VERIFY:
                legal = 1'b1;
            default:
                legal = 1'b0;
        endcase
    end

    // The host side of the AXI4-Lite write channels.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_r     <= 1'b0;
            w_hold_r      <= 1'b0;
            waddr_r       <= '0;
            wdat_r        <= '0;
            wfull_r       <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end
        else
        begin
            if (aw_fire)
                waddr_r <= s_axi_awaddr;
            if (w_fire)
                wdat_r <= s_axi_wdata;
            if (w_fire)
                wfull_r <= &s_axi_wstrb;
            aw_hold_r     <= (aw_hold_r | aw_fire) & ~wr_do;
            w_hold_r      <= (w_hold_r | w_fire) & ~wr_do;
            s_axi_awready <= ~((aw_hold_r | aw_fire) & ~wr_do) & ~wr_do & ~(s_axi_bvalid & ~s_axi_bready);
            s_axi_wready  <= ~((w_hold_r | w_fire) & ~wr_do) & ~wr_do & ~(s_axi_bvalid & ~s_axi_bready);
            if (wr_do)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wa > REG_SHADOW || wa == REG_RDATA || wa == REG_STATUS) ? RESP_SLVERR : RESP_OKAY;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // The host side of the AXI4-Lite read channels.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= ~(s_axi_arvalid & s_axi_arready) & ~(s_axi_rvalid & ~s_axi_rready);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= RESP_OKAY;
                unique case (s_axi_araddr)
                    REG_CMD:    s_axi_rdata <= {29'h0, op_r};
                    REG_ADDR:   s_axi_rdata <= {10'h0, addr_r};
                    REG_WDATA:  s_axi_rdata <= {16'h0, wdata_r};
                    REG_RDATA:  s_axi_rdata <= {16'h0, rdata_r};
                    REG_STATUS: s_axi_rdata <= {28'h0, grp_prot_r, refused_r, done_r, hst_r == H_RUN};
                    REG_CFG:    s_axi_rdata <= {29'h0, cfg_r};
                    REG_SHADOW: s_axi_rdata <= shadow_r;
                    default:
                    begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // Software parameters and the flash reset and elevated voltage pins.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            addr_r              <= '0;
            wdata_r             <= '0;
            cfg_r               <= '0;
            fl_reset_n          <= 1'b0;
            elevated_id_voltage <= 1'b0;
        end
        else
        begin
            if (wr_do && w_full && hst_r == H_IDLE)
            begin
                if (wa == REG_ADDR)
                    addr_r <= wd[FL_AW-1:0];
                if (wa == REG_WDATA)
                    wdata_r <= wd[FL_DW-1:0];
                if (wa == REG_CFG)
                    cfg_r <= wd[2:0];
            end
            if (cfg_r[CFG_RST])
                cfg_r[CFG_SEC] <= 1'b0; // [RL12]
            fl_reset_n          <= ~cfg_r[CFG_RST];
            elevated_id_voltage <= cfg_r[CFG_ELEV]; // [RL24]
        end
    end

    // Command sequencer: one flash bus cycle per accepted order.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            hst_r      <= H_IDLE;
            op_r       <= OP_WRITE;
            cyc.req    <= 1'b0;
            cyc.wr     <= 1'b0;
            cyc.addr   <= '0;
            cyc.wdata  <= '0;
            rdata_r    <= '0;
            done_r     <= 1'b0;
            refused_r  <= 1'b0;
            grp_prot_r <= 1'b0;
            shadow_r   <= '0;
        end
        else
        begin
            cyc.req <= 1'b0;
            unique case (hst_r)
                H_IDLE:
                    if (cmd_wr)
                    begin
                        op_r      <= wd[2:0];
                        done_r    <= 1'b0;
                        refused_r <= ~legal;
                        if (legal)
                        begin
                            hst_r     <= H_RUN;
                            cyc.req   <= 1'b1;
                            cyc.wr    <= (wd[2:0] != OP_READ) && (wd[2:0] != OP_VERIFY);
                            cyc.wdata <= wdata_r;
                            cyc.addr  <= (wd[2:0] == OP_VERIFY) ? ({grp, 17'h0} | VERIFY_LOW) : addr_r; // [RL23]
                        end
                    end
                H_RUN:
                    if (cyc.done)
                    begin
                        hst_r   <= H_IDLE;
                        done_r  <= 1'b1;
                        rdata_r <= cyc.rdata;
                        if (op_r == OP_VERIFY)
                            grp_prot_r <= cyc.rdata[0]; // [RL23]
                        if (op_r == OP_PROTECT && !cfg_r[CFG_SEC])
                            shadow_r[grp] <= 1'b1; // [RL4]
                        if (op_r == OP_UNPROTECT)
                            shadow_r <= '0; // [RL5]
                    end
            endcase
        end
    end
endmodule : fsp_host
`default_nettype wire

// File: design/fsp_pkg.sv
package fsp_pkg;
    localparam int          AXI_AW        = 8;
    localparam int          FL_AW         = 22;
    localparam int          FL_DW         = 16;
    localparam int          GRP_W         = 5;
    localparam int          GRP_LSB       = 17;
    localparam int          NUM_GRP       = 32;
    localparam int          CLK_MHZ       = 100;
    localparam int          GLITCH_NS     = 5;
    localparam int          SETUP_NS      = 20;
    localparam int          STROBE_NS     = 50;
    localparam int          HOLD_NS       = 20;
    localparam int          SETUP_CYC     = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int          STROBE_RAW    = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int          GLITCH_CYC    = (GLITCH_NS * CLK_MHZ + 999) / 1000 + 1;
    localparam int          STROBE_CYC    = (STROBE_RAW > GLITCH_CYC) ? STROBE_RAW : GLITCH_CYC;
    localparam int          HOLD_CYC      = (HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0]  REG_CMD       = 8'h00;
    localparam logic [7:0]  REG_ADDR      = 8'h04;
    localparam logic [7:0]  REG_WDATA     = 8'h08;
    localparam logic [7:0]  REG_RDATA     = 8'h0c;
    localparam logic [7:0]  REG_STATUS    = 8'h10;
    localparam logic [7:0]  REG_CFG       = 8'h14;
    localparam logic [7:0]  REG_SHADOW    = 8'h18;
    localparam logic [2:0]  OP_WRITE      = 3'h0;
    localparam logic [2:0]  OP_READ       = 3'h1;
    localparam logic [2:0]  OP_PROTECT    = 3'h2;
    localparam logic [2:0]  OP_UNPROTECT  = 3'h3;
    localparam logic [2:0]  OP_VERIFY     = 3'h4;
    localparam int          CFG_ELEV      = 0;
    localparam int          CFG_RST       = 1;
    localparam int          CFG_SEC       = 2;
    localparam int          ST_BUSY       = 0;
    localparam int          ST_DONE       = 1;
    localparam int          ST_REFUSED    = 2;
    localparam int          ST_GRP_PROT   = 3;
    localparam logic [21:0] VERIFY_LOW    = 22'h000002;
    localparam logic [14:0] SEC_LIMIT     = 15'h007f;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : fsp_pkg

// File: design/fsp_cyc_if.sv
`timescale 1ns/1ns
`default_nettype none
interface fsp_cyc_if;
    import fsp_pkg::*;
    logic             req;
    logic             wr;
    logic [FL_AW-1:0] addr;
    logic [FL_DW-1:0] wdata;
    logic             done;
    logic [FL_DW-1:0] rdata;
    modport ctl (output req, wr, addr, wdata, input done, rdata);
    modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface : fsp_cyc_if
`default_nettype wire

// File: design/fsp_cycle.sv
`timescale 1ns/1ns
`default_nettype none
module fsp_cycle (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    fsp_cyc_if.eng                         cyc,
    output var  logic [fsp_pkg::FL_AW-1:0] fl_addr_r,
    output var  logic [fsp_pkg::FL_DW-1:0] fl_dq_o_r,
    output var  logic                      fl_dq_oe_r,
    input  wire logic [fsp_pkg::FL_DW-1:0] fl_dq_i,
    output var  logic                      fl_ce_n_r,
    output var  logic                      fl_oe_n_r,
    output var  logic                      fl_we_n_r
);
    import fsp_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE   = 4'b0001,
        S_SETUP  = 4'b0010,
        S_STROBE = 4'b0100,
        S_HOLD   = 4'b1000
    } fsp_cst_t;

    fsp_cst_t   state_r;
    fsp_cst_t   state_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic       wr_r;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = (cnt_r == 8'h00) ? 8'h00 : cnt_r - 8'h01;
        unique case (state_r)
            S_IDLE:
                if (cyc.req)
                begin
                    state_nxt = S_SETUP;
                    cnt_nxt   = 8'(SETUP_CYC - 1);
                end
            S_SETUP:
                if (cnt_r == 8'h00)
                begin
                    state_nxt = S_STROBE;
                    cnt_nxt   = 8'(STROBE_CYC - 1);
                end
            S_STROBE:
                if (cnt_r == 8'h00)
                begin
                    state_nxt = S_HOLD;
                    cnt_nxt   = 8'(HOLD_CYC - 1);
                end
            S_HOLD:
                if (cnt_r == 8'h00)
                    state_nxt = S_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= S_IDLE;
            cnt_r   <= 8'h00;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // Address and data are captured when the cycle is accepted and held to its end.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_r      <= 1'b0;
            fl_addr_r <= '0;
            fl_dq_o_r <= '0;
        end
        else if (state_r == S_IDLE && cyc.req)
        begin
            wr_r      <= cyc.wr;
            fl_addr_r <= cyc.addr;
            fl_dq_o_r <= cyc.wdata;
        end
    end

    // Write enable falls only under chip select with output enable high, for longer than a glitch. [RL21]
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fl_ce_n_r  <= 1'b1;
            fl_oe_n_r  <= 1'b1;
            fl_we_n_r  <= 1'b1;
            fl_dq_oe_r <= 1'b0;
        end
        else
        begin
            fl_ce_n_r  <= (state_nxt == S_IDLE);
            fl_oe_n_r  <= wr_nxt() | (state_nxt == S_IDLE) | (state_nxt == S_HOLD);
            fl_we_n_r  <= ~(wr_nxt() & (state_nxt == S_STROBE));
            fl_dq_oe_r <= wr_nxt() & (state_nxt != S_IDLE);
        end
    end

    function automatic logic wr_nxt();
        wr_nxt = (state_r == S_IDLE) ? cyc.wr : wr_r;
    endfunction

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cyc.done  <= 1'b0;
            cyc.rdata <= '0;
        end
        else
        begin
            cyc.done <= (state_r == S_HOLD) && (cnt_r == 8'h00);
            if (state_r == S_STROBE && cnt_r == 8'h00 && !wr_r)
                cyc.rdata <= fl_dq_i;
        end
    end
endmodule : fsp_cycle
`default_nettype wire

// File: verification/fsp_host_sva.sv
`timescale 1ns/1ns
`default_nettype none
module fsp_host_sva (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [21:0] fl_addr,
    input wire logic        fl_dq_oe,
    input wire logic        fl_ce_n,
    input wire logic        fl_oe_n,
    input wire logic        fl_we_n
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wr_gate_a: assert property (!fl_we_n |-> !fl_ce_n && fl_oe_n && fl_dq_oe)
        else $error("write strobe outside a selected write");
    no_clash_a: assert property (!fl_oe_n |-> !fl_dq_oe && fl_we_n)
        else $error("host drives data while flash outputs");
    we_width_a: assert property ($fell(fl_we_n) |-> !fl_we_n [*5])
        else $error("write strobe shorter than five cycles");
    we_setup_a: assert property ($fell(fl_we_n) |-> $past(!fl_ce_n) && $past(!fl_ce_n, 2))
        else $error("chip select setup before write strobe too short");
    we_hold_a: assert property ($rose(fl_we_n) |-> !fl_ce_n [*2] ##1 fl_ce_n)
        else $error("chip select hold after write strobe wrong");
    addr_steady_a: assert property (!fl_ce_n && $past(!fl_ce_n) |-> $stable(fl_addr))
        else $error("flash address moved inside a cycle");
    b_answer_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write response missing after address and data");
    b_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    r_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
endmodule // fsp_host_sva
bind fsp_host fsp_host_sva chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .fl_addr(fl_addr), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n));
`default_nettype wire

// File: verification/fsp_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
module fsp_flash_model (
    input  wire logic [21:0] fl_addr,
    input  wire logic [15:0] fl_dq_o,
    input  wire logic        fl_ce_n,
    input  wire logic        fl_oe_n,
    input  wire logic        fl_we_n,
    input  wire logic        fl_reset_n,
    input  wire logic        elevated_id_voltage,
    input  wire logic [31:0] prot_grp,
    output var  logic [15:0] fl_dq_i
);
    logic [15:0] mem [int];
    logic [15:0] last_q = 16'h0000;
    logic [15:0] val;
    // Writes land on the strobe's rising edge and only when the group is unprotected or elevated voltage is applied.
    always @(posedge fl_we_n)
        if (!fl_ce_n && fl_oe_n && fl_reset_n
            && (!prot_grp[fl_addr[21:17]] || elevated_id_voltage))
            mem[int'(fl_addr)] = fl_dq_o;
    // A released bus shows the inverse of the last value, never a held copy.
    always @(fl_addr, fl_ce_n, fl_oe_n, prot_grp)
        if (!fl_ce_n && !fl_oe_n)
        begin
            if (fl_addr[16:0] == 17'h00002)
                val = {15'h0000, prot_grp[fl_addr[21:17]]};
            else
                val = mem.exists(int'(fl_addr)) ? mem[int'(fl_addr)] : 16'hffff;
            fl_dq_i = val;
            last_q = val;
        end
        else
            fl_dq_i = ~last_q;
endmodule // fsp_flash_model
`default_nettype wire

// File: verification/fsp_host_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module fsp_host_tb_top;
    import fsp_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, dq_oe, ce_n, oe_n, we_n, rst_n, elev, e;
    logic [7:0]  awaddr, araddr;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] wdata, rdata, st, d, prot;
    logic [21:0] fa, a;
    logic [15:0] dqo, dqi;
    logic [15:0] exp_mem [int];
    int          failures, n_checks, g;

    fsp_host dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fl_addr(fa), .fl_dq_o(dqo),
        .fl_dq_oe(dq_oe), .fl_dq_i(dqi), .fl_ce_n(ce_n), .fl_oe_n(oe_n), .fl_we_n(we_n),
        .fl_reset_n(rst_n), .elevated_id_voltage(elev));
    fsp_flash_model flash (.fl_addr(fa), .fl_dq_o(dqo), .fl_ce_n(ce_n), .fl_oe_n(oe_n), .fl_we_n(we_n),
        .fl_reset_n(rst_n), .elevated_id_voltage(elev), .prot_grp(prot), .fl_dq_i(dqi));

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("checks=%0d mismatches=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic axw(input logic [7:0] ad, input logic [31:0] dd, input logic [3:0] s, output logic [1:0] rr);
        @(posedge aclk);
        awaddr <= ad;
        wdata <= dd;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid)
            begin
                rr = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic axr(input logic [7:0] ad, output logic [31:0] dd, output logic [1:0] rr);
        @(posedge aclk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid)
            begin
                dd = rdata;
                rr = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] dd);
        logic [1:0] rr;
        axw(ad, dd, 4'hf, rr);
        chk({30'h0, rr}, {30'h0, RESP_OKAY});
    endtask

    task automatic rdc(input logic [7:0] ad, input logic [31:0] exp);
        logic [31:0] dd;
        logic [1:0]  rr;
        axr(ad, dd, rr);
        chk(dd, exp);
        chk({30'h0, rr}, {30'h0, RESP_OKAY});
    endtask

    task automatic op(input logic [2:0] c, output logic [31:0] s);
        logic [1:0] rr;
        wr(REG_CMD, {29'h0, c});
        do axr(REG_STATUS, s, rr); while (s[ST_BUSY] !== 1'b0);
    endtask

    initial
    begin
        #500000;
        failures++;
        close_out();
    end

    initial
    begin
        failures = 0;
        n_checks = 0;
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wstrb, wdata} = 52'h0;
        prot = 32'h0;
        void'($urandom(40379));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rdc(REG_STATUS, 32'h0);
        rdc(REG_CFG, 32'h0);
        axr(8'h1c, d, r);
        chk(d, 32'h0);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        axw(REG_STATUS, 32'h1, 4'hf, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        axw(REG_ADDR, 32'h3, 4'h3, r);
        rdc(REG_ADDR, 32'h0);
        $display("test registers done");
        prot <= $urandom;
        for (int i = 0; i < 8; i++)
        begin
            g = $urandom % 32;
            e = i[0];
            a = {g[4:0], 1'b1, 16'(i * 4 + 3)};
            d = {16'h0, 16'($urandom)};
            wr(REG_CFG, {31'h0, e});
            wr(REG_ADDR, {10'h0, a});
            wr(REG_WDATA, d);
            op(OP_WRITE, st);
            chk({29'h0, st[2:0]}, 32'h2);
            if (!prot[g] || e) exp_mem[int'(a)] = d[15:0];
            op(OP_READ, st);
            rdc(REG_RDATA, exp_mem.exists(int'(a)) ? {16'h0, exp_mem[int'(a)]} : 32'hffff);
        end
        $display("test program and read done");
        wr(REG_CFG, 32'h0);
        for (int i = 0; i < NUM_GRP; i++)
        begin
            wr(REG_ADDR, 32'(i) << GRP_LSB);
            op(OP_VERIFY, st);
            chk({29'h0, st[3:1]}, {29'h0, prot[i], 2'b01});
        end
        $display("test group verify done");
        for (int c = 5; c < 8; c++)
        begin
            op(3'(c), st);
            chk({29'h0, st[2:0]}, 32'h4);
        end
        op(OP_PROTECT, st);
        chk({29'h0, st[2:0]}, 32'h4);
        wr(REG_CFG, 32'h1);
        op(OP_UNPROTECT, st);
        chk({29'h0, st[2:0]}, 32'h4);
        wr(REG_CFG, 32'h4);
        wr(REG_ADDR, 32'h80);
        op(OP_READ, st);
        chk({29'h0, st[2:0]}, 32'h4);
        wr(REG_ADDR, {25'h0, SEC_LIMIT[6:0]});
        op(OP_READ, st);
        chk({29'h0, st[2:0]}, 32'h2);
        wr(REG_CFG, 32'h6);
        rdc(REG_CFG, 32'h2);
        chk({31'h0, rst_n}, 32'h0);
        wr(REG_CFG, 32'h1);
        $display("test refusals done");
        for (int i = 0; i < NUM_GRP; i++)
        begin
            wr(REG_ADDR, 32'(i) << GRP_LSB);
            op(OP_PROTECT, st);
            chk({29'h0, st[2:0]}, 32'h2);
        end
        rdc(REG_SHADOW, 32'hffffffff);
        op(OP_UNPROTECT, st);
        chk({29'h0, st[2:0]}, 32'h2);
        rdc(REG_SHADOW, 32'h0);
        wr(REG_CFG, 32'h0);
        $display("test protect cycle done");
        close_out();
    end
endmodule // fsp_host_tb_top
`default_nettype wire
